// [common/asc_map.svh]
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// Clock rate and derived figures.
`define ASC_CLK_PERIOD_NS 40
// Timing figures in ns.
`define ASC_READ_CYCLE_TIME_NS 70
`define ASC_ADDRESS_ACCESS_TIME_NS 70
`define ASC_OE_ACCESS_NS 35
`define ASC_ADDRESS_TO_WRITE_END_NS 60
`define ASC_DATA_TO_WRITE_END_NS 30
`define ASC_WE_TO_HIGHZ_MAX_NS 30
`define ASC_WRITE_PULSE_MIN_NS 50
`define ASC_RELEASE_MAX_NS 30
// Least times round up to whole cycles, never below one.
`define ASC_CEIL_CYC(ns) ((((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS))
// Cycles the read strobes stay low, one beyond the access time.
`define ASC_READ_ACCESS_CYC (`ASC_CEIL_CYC(`ASC_ADDRESS_ACCESS_TIME_NS) + 1)
// Write pulse with output enable high and low (bus turn-around included).
`define ASC_WRITE_PULSE_CYC `ASC_CEIL_CYC(`ASC_WRITE_PULSE_MIN_NS + 10)
`define ASC_WRITE_PULSE_OE_CYC `ASC_CEIL_CYC(`ASC_DATA_TO_WRITE_END_NS + `ASC_WE_TO_HIGHZ_MAX_NS)
// Idle gap after a read so the memory releases the pins.
`define ASC_TURN_CYC `ASC_CEIL_CYC(`ASC_RELEASE_MAX_NS)
// Recovery after leaving retention.
`define ASC_RECOVER_CYC `ASC_CEIL_CYC(`ASC_READ_CYCLE_TIME_NS)
// Reset values of the pins.
`define ASC_ADDR_RESET 19'h00000
`define ASC_DATA_RESET 8'h00

`endif

// [common/asc_pkg.sv]
package asc_pkg;
    typedef logic [18:0] asc_addr_type;
    typedef logic [7:0] asc_data_type;
    typedef enum logic [5:0] {
        ASC_IDLE = 6'h01,
        ASC_READ = 6'h02,
        ASC_WRITE = 6'h04,
        ASC_TURN = 6'h08,
        ASC_RETAIN = 6'h10,
        ASC_RECOVER = 6'h20
    } asc_state_type;
endpackage : asc_pkg

// [hw/asc_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module asc_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Asynchronous input and its synchronised copy.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            stage1_reg <= '0;
            sync_out <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end
endmodule : asc_sync
`default_nettype wire

// [hw/asc_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
`include "asc_map.svh"
module asc_ctrl (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // User request port.
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_oe_low_write,
    input wire asc_pkg::asc_addr_type req_addr,
    input wire asc_pkg::asc_data_type req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output asc_pkg::asc_data_type rsp_rdata,
    // Retention control.
    input wire logic retain_req,
    output logic retain_active,
    // Memory pins.
    output asc_pkg::asc_addr_type word_address,
    output logic chip_sel_b,
    output logic out_en_b,
    output logic write_en_b,
    input wire asc_pkg::asc_data_type shared_data_pins_in,
    output asc_pkg::asc_data_type shared_data_pins_out,
    output logic shared_data_pins_oe
);
    import asc_pkg::*;

    localparam logic [3:0] READ_CYC = 4'(`ASC_READ_ACCESS_CYC);
    localparam logic [3:0] WR_CYC = 4'(`ASC_WRITE_PULSE_CYC);
    localparam logic [3:0] WR_OE_CYC = 4'(`ASC_WRITE_PULSE_OE_CYC);
    localparam logic [3:0] TURN_CYC = 4'(`ASC_TURN_CYC);
    localparam logic [3:0] RECOVER_CYC = 4'(`ASC_RECOVER_CYC);

    asc_state_type state_reg;
    logic [3:0] count_reg;
    logic write_oe_reg;
    asc_data_type data_sync;
    logic count_done;
    logic [1:0] rd_pend_reg;

    // ==========================================================
    // Read data synchroniser.
    asc_sync #(
        .WIDTH(8)
    ) u_data_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in(shared_data_pins_in),
        .sync_out(data_sync)
    );

    assign count_done = (count_reg == 4'h1);

    // ==========================================================
    // Sequencer.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg <= ASC_IDLE;
            count_reg <= 4'h0;
            write_oe_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ASC_IDLE: begin
                    if (retain_req) begin
                        state_reg <= ASC_RETAIN;
                    end else if (req_valid) begin
                        write_oe_reg <= req_oe_low_write;
                        if (req_write) begin
                            state_reg <= ASC_WRITE;
                            count_reg <= req_oe_low_write ? WR_OE_CYC : WR_CYC;
                        end else begin
                            state_reg <= ASC_READ;
                            count_reg <= READ_CYC;
                        end
                    end
                end
                ASC_READ: begin
                    count_reg <= count_reg - 4'h1;
                    if (count_done) begin
                        state_reg <= ASC_TURN;
                        count_reg <= TURN_CYC;
                    end
                end
                ASC_WRITE: begin
                    count_reg <= count_reg - 4'h1;
                    if (count_done) begin
                        state_reg <= ASC_TURN;
                        count_reg <= TURN_CYC;
                    end
                end
                ASC_TURN: begin
                    count_reg <= count_reg - 4'h1;
                    if (count_done) begin
                        state_reg <= ASC_IDLE;
                    end
                end
                ASC_RETAIN: begin
                    if (!retain_req) begin
                        state_reg <= ASC_RECOVER;
                        count_reg <= RECOVER_CYC;
                    end
                end
                ASC_RECOVER: begin
                    count_reg <= count_reg - 4'h1;
                    if (count_done) begin
                        state_reg <= ASC_IDLE;
                    end
                end
                default: begin
                    state_reg <= ASC_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Pin drive. Select and enables change together with the address
    // latched one edge earlier, so address leads each strobe.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            word_address <= `ASC_ADDR_RESET;
            shared_data_pins_out <= `ASC_DATA_RESET;
        end else if (state_reg == ASC_IDLE && req_valid && !retain_req) begin
            word_address <= req_addr;
            shared_data_pins_out <= req_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            chip_sel_b <= 1'b1;
            out_en_b <= 1'b1;
            write_en_b <= 1'b1;
            shared_data_pins_oe <= 1'b0;
        end else begin
            // Strobes cover every cycle of the access state, so a count of N
            // holds them low for N whole cycles.
            // Select and write enable fall together, so the write starts on
            // one edge and the memory keeps its pins released.
            chip_sel_b <= !(state_reg == ASC_READ || state_reg == ASC_WRITE);
            out_en_b <= !(state_reg == ASC_READ
                || (state_reg == ASC_WRITE && write_oe_reg));
            // Both strobes rise on the same edge while data is still held.
            write_en_b <= !(state_reg == ASC_WRITE);
            // Data is driven only inside the write pulse and held to its end.
            shared_data_pins_oe <= (state_reg == ASC_WRITE);
        end
    end

    // ==========================================================
    // Read capture and handshake outputs.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_pend_reg <= 2'h0;
            rsp_valid <= 1'b0;
            rsp_rdata <= `ASC_DATA_RESET;
        end else begin
            // The pins are sampled at the edge that leaves ASC_READ, which starts the last strobe
            // cycle; that copy needs two more edges to leave the synchroniser.
            rd_pend_reg <= {rd_pend_reg[0], (state_reg == ASC_READ) && count_done};
            rsp_valid <= rd_pend_reg[1];
            if (rd_pend_reg[1]) begin
                rsp_rdata <= data_sync;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            req_ready <= 1'b0;
            retain_active <= 1'b0;
        end else begin
            req_ready <= (state_reg == ASC_TURN && count_done)
                || (state_reg == ASC_RECOVER && count_done)
                || (state_reg == ASC_IDLE && !req_valid && !retain_req);
            retain_active <= (state_reg == ASC_RETAIN);
        end
    end
endmodule : asc_ctrl
`default_nettype wire

// [test/asc_ctrl_props.sv]
`timescale 1ns/1ns
`default_nettype none
module asc_ctrl_props (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Request side.
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_ready,
    input wire logic retain_req,
    input wire asc_pkg::asc_addr_type req_addr,
    input wire asc_pkg::asc_data_type req_wdata,
    input wire logic rsp_valid,
    input wire logic retain_active,
    // Memory pins.
    input wire logic chip_sel_b,
    input wire logic out_en_b,
    input wire logic write_en_b,
    input wire logic shared_data_pins_oe,
    input wire asc_pkg::asc_addr_type word_address,
    input wire asc_pkg::asc_data_type shared_data_pins_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence take(w); req_valid && req_ready && !retain_req && req_write == w; endsequence
    sequence rd_on; (!chip_sel_b && !out_en_b && write_en_b)[*3]; endsequence
    sequence wr_on; (!chip_sel_b && !write_en_b && shared_data_pins_oe)[*2]; endsequence
    a_read_walk: assert property (
        take(1'h0) |=> ##1 rd_on ##1 (chip_sel_b && out_en_b) ##1 rsp_valid)
        else $error("read walk");
    a_read_addr: assert property (
        take(1'h0) |=> word_address == $past(req_addr)) else $error("read address");
    a_write_walk: assert property (
        take(1'h1) |=> ##1 wr_on ##1 (chip_sel_b && write_en_b)) else $error("write walk");
    a_write_value: assert property (
        take(1'h1) |=> shared_data_pins_out == $past(req_wdata) && word_address == $past(req_addr))
        else $error("write value");
    a_write_stable: assert property (
        !write_en_b && !$past(write_en_b) |-> $stable(shared_data_pins_out) && $stable(word_address))
        else $error("write data moved");
    a_no_contention: assert property (
        !chip_sel_b && !out_en_b && write_en_b |-> !shared_data_pins_oe) else $error("contention");
    a_read_release: assert property (
        $rose(out_en_b) |-> !shared_data_pins_oe[*2]) else $error("drive after read");
    a_retain_sel: assert property (retain_active |-> chip_sel_b) else $error("retain select");
    a_recover_gap: assert property (
        $fell(retain_active) |-> chip_sel_b[*2]) else $error("recovery short");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("rsp not pulse");
    a_cycle_space: assert property (
        $rose(chip_sel_b) |=> chip_sel_b) else $error("cycles too close");
endmodule : asc_ctrl_props
bind asc_ctrl asc_ctrl_props i_asc_ctrl_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .req_valid(req_valid), .req_write(req_write), .req_ready(req_ready),
    .retain_req(retain_req), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .retain_active(retain_active), .chip_sel_b(chip_sel_b), .out_en_b(out_en_b),
    .write_en_b(write_en_b), .shared_data_pins_oe(shared_data_pins_oe),
    .word_address(word_address), .shared_data_pins_out(shared_data_pins_out));
`default_nettype wire

// [test/asc_sram_model.sv]
`timescale 1ns/1ns
`default_nettype none
module asc_sram_model (
    // Memory pins and the slow-access switch.
    input wire logic chip_sel_b,
    input wire logic out_en_b,
    input wire logic write_en_b,
    input wire asc_pkg::asc_addr_type word_address,
    input wire asc_pkg::asc_data_type din,
    input wire logic slow,
    output asc_pkg::asc_data_type dout
);
    import asc_pkg::*;
    asc_data_type mem [asc_addr_type];
    asc_data_type vis;
    asc_data_type last = 8'h00;
    logic drive;
    assign drive = !chip_sel_b && write_en_b && !out_en_b;
    always @* begin
        if (!chip_sel_b && !write_en_b) begin
            mem[word_address] = din;
        end
    end
    // A released bus shows the inverse of the last byte, never a stale copy.
    always @* begin
        if (drive) begin
            vis = mem.exists(word_address) ? mem[word_address] : 8'h5A;
            last = vis;
        end else begin
            vis = ~last;
        end
    end
    always @(vis) begin
        dout <= #((slow && drive) ? 65 : 5) vis;
    end
endmodule : asc_sram_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
    import asc_pkg::*;
    logic ref_clk = 1'h0, rst_b = 1'h0, req_valid = 1'h0, req_write = 1'h0;
    logic req_oe_low_write = 1'h0, retain_req = 1'h0, slow = 1'h0;
    logic req_ready, rsp_valid, retain_active, chip_sel_b, out_en_b, write_en_b, pins_oe;
    asc_addr_type req_addr = 19'h00000, word_address;
    asc_data_type req_wdata = 8'h00, rsp_rdata, pins_in, pins_out, dout;
    asc_addr_type at [4] = '{19'h00000, 19'h7FFFF, 19'h2AAAA, 19'h15555};
    asc_data_type dt [4] = '{8'h3C, 8'hC3, 8'hFF, 8'h00};
    int err_total = 0, comparisons = 0, cyc = 0;
    assign pins_in = pins_oe ? pins_out : dout;
    always #20 ref_clk = ~ref_clk;
    asc_ctrl i_asc_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid),
        .req_write(req_write), .req_oe_low_write(req_oe_low_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .retain_req(retain_req), .retain_active(retain_active),
        .word_address(word_address), .chip_sel_b(chip_sel_b), .out_en_b(out_en_b),
        .write_en_b(write_en_b), .shared_data_pins_in(pins_in),
        .shared_data_pins_out(pins_out), .shared_data_pins_oe(pins_oe));
    asc_sram_model i_asc_sram_model (.chip_sel_b(chip_sel_b), .out_en_b(out_en_b),
        .write_en_b(write_en_b), .word_address(word_address), .din(pins_out),
        .slow(slow), .dout(dout));
    task check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task complete_run;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    task tick;
        @(posedge ref_clk);
        #1;
    endtask : tick
    task send(input logic w, oel, input asc_addr_type a, input asc_data_type d);
        int n;
        n = 0;
        while (req_ready !== 1'h1 && n < 60) begin tick; n++; end
        {req_write, req_oe_low_write, req_addr, req_wdata} = {w, oel, a, d};
        req_valid = 1'h1;
        tick;
        req_valid = 1'h0;
    endtask : send
    task read_chk(input asc_addr_type a, input asc_data_type exp);
        int n;
        n = 0;
        send(1'h0, 1'h0, a, 8'h00);
        while (rsp_valid !== 1'h1 && n < 10) begin tick; n++; end
        check("read latency", n, 5);
        check("read data", rsp_rdata, exp);
    endtask : read_chk
    task sc_reset;
        check("idle pins", {chip_sel_b, out_en_b, write_en_b, pins_oe}, 4'hE);
        check("reset address", word_address, 19'h00000);
    endtask : sc_reset
    task sc_rw;
        for (int i = 0; i < 4; i++) send(1'h1, i[0], at[i], dt[i]);
        for (int i = 0; i < 4; i++) read_chk(at[i], dt[i]);
    endtask : sc_rw
    task sc_slow;
        slow = 1'h1;
        read_chk(at[1], dt[1]);
        slow = 1'h0;
    endtask : sc_slow
    task sc_retain;
        int n;
        n = 0;
        retain_req = 1'h1;
        while (retain_active !== 1'h1 && n < 20) begin tick; n++; end
        check("retain select", {retain_active, chip_sel_b}, 2'h3);
        {req_write, req_addr, req_wdata} = {1'h1, at[2], 8'h77};
        req_valid = 1'h1;
        repeat (5) tick;
        req_valid = 1'h0;
        retain_req = 1'h0;
        read_chk(at[2], dt[2]);
    endtask : sc_retain
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            complete_run;
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 rst_b = 1'h1;
        sc_reset;
        sc_rw;
        sc_slow;
        sc_retain;
        complete_run;
    end
endmodule : tb
`default_nettype wire
